// File: include/pmc_doze_if.sv
// Interface carrying doze settings to the core clock divider.
`timescale 1ns/1ps
interface pmc_doze_if;
	logic enable;
	logic [2:0] ratio;
	logic core_tick;
	modport ctrl (output enable, output ratio, input core_tick);
	modport div (input enable, input ratio, output core_tick);
endinterface : pmc_doze_if

// File: include/pmc_pkg.sv
// Package of constants and types for the power mode clock gating block.
package pmc_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CLOCK_DIVIDER_REGISTER = 4'h4;
	localparam logic [3:0] ADDR_MOD = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	// Field positions inside the clock divider register.
	localparam int CLOCK_DIVIDER_REGISTER_ROI_POS = 15;
	localparam int CLOCK_DIVIDER_REGISTER_RATIO_LSB = 12;
	localparam int CLOCK_DIVIDER_REGISTER_CORE_SLOWDOWN_ENABLE_POS = 11;
	// Field positions inside the control register.
	localparam int CTRL_GO_POS = 0;
	localparam int CTRL_OPER_POS = 1;
	localparam int CTRL_WDT_POS = 2;
	localparam int CTRL_FAILSAFE_CLOCK_MONITOR_POS = 3;
	localparam int CTRL_REGULATOR_STANDBY_KEEP_BIT_POS = 8;
	localparam int CTRL_LOCK_POS = 9;
	localparam int CTRL_NEW_OSCILLATOR_SELECT_LSB = 12;
	// Values after reset.
	localparam logic [15:0] CLOCK_DIVIDER_REGISTER_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [2:0] OSC_RST = 3'h0;
	// Regulator wake delay in ns and its count of 10 MHz cycles.
	localparam int CLK_PERIOD_NS = 100;
	localparam int REG_WAKE_NS = 10000;
	localparam int REG_WAKE_CYC = (REG_WAKE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Oscillator restart delay in ns and its cycle count.
	localparam int OSC_START_NS = 1000;
	localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Power mode state machine, one-hot.
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SLEEP = 4'h2,
		ST_IDLE = 4'h4,
		ST_WAKE = 4'h8
	} pmc_state_t;
endpackage : pmc_pkg

// File: rtl/pmc_doze_div.sv
// Core clock enable divider for doze mode.
`timescale 1ns/1ps
module pmc_doze_div (
	input wire logic i_clk,
	input wire logic i_rst_b,
	pmc_doze_if.div dz
);
	// Free counter; the peripheral clock never stops, only core ticks thin.
	logic [6:0] cnt_r;
	logic [6:0] mask;
	logic hit;
	// Code n keeps one tick out of two to the power n.
	assign mask = 7'((8'h01 << dz.ratio) - 8'h01);
	assign hit = ((cnt_r & mask) == 7'h00);

	// Counter runs on every peripheral edge so both domains stay aligned.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_r + 7'h01;
		end
	end

	// With doze off the core ticks every cycle.
	assign dz.core_tick = dz.enable ? hit : 1'b1;
endmodule : pmc_doze_div

// File: rtl/pmc_top.sv
// Power mode and clock gating controller with an Avalon-MM register slave.
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - Operand zero sleeps, operand one idles.
// - Sleep stops oscillator and all execution.
// - Idle stops core, keeps system clock.
// - Enabled interrupt, reset or watchdog wakes.
// - Watchdog cleared on sleep or idle entry.
// - Low-power oscillator kept when watchdog/monitor need it.
// - Fail-safe monitor off during sleep.
// - System-clocked peripherals disabled in sleep.
// - Regulator standby adds wake delay unless kept.
// - Sleep wake resumes previous oscillator.
// - Idle wake reapplies core clock at once.
// - Interrupt during entry held, then wakes.
// - Doze slows core only, domains aligned.
// - Doze enable bit turns doze on.
// - Three-bit ratio, reset default one to one.
// - Return-on-interrupt ends doze on interrupt.
// - Clock disable removes module clocks, blocks access.
// - Function enable clear stops module, registers live.
// - Stop-in-idle halts module in idle.
// - New oscillator accepted only when unlocked.
module pmc_top #(
	parameter int NMOD = 8,
	parameter int REG_WAKE_CYCLES = pmc_pkg::REG_WAKE_CYC
) (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic [3:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	input wire logic I_POWER_SAVE_INSTRUCTION,
	input wire logic I_POWER_SAVE_INSTRUCTION_OPER,
	input wire logic I_IRQ_PEND,
	input wire logic I_WDT_TIMEOUT,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	output logic O_CORE_CLK_EN,
	output logic O_SYS_OSC_ON,
	output logic O_LOW_POWER_INTERNAL_OSCILLATOR_ON,
	output logic O_FAILSAFE_CLOCK_MONITOR_ACTIVE,
	output logic O_WDT_CLEAR,
	output logic O_REG_STANDBY,
	output logic [2:0] O_OSC_SEL,
	output logic [NMOD-1:0] O_MOD_CLK_EN,
	output logic [NMOD-1:0] O_MOD_RUN,
	output logic [NMOD-1:0] O_MOD_REG_ACCESS
);
	// Doze signals travel through an interface to the divider.
	pmc_doze_if dz ();

	// Software registers.
	logic [15:0] ctrl_r;
	logic [15:0] clock_divider_register_r;
	logic [NMOD-1:0] mod_dis_r;
	logic [NMOD-1:0] mod_en_r;
	logic [NMOD-1:0] mod_idl_r;
	logic [2:0] osc_run_r;
	// Power state, its next value and the wake counter.
	pmc_pkg::pmc_state_t state_r;
	pmc_pkg::pmc_state_t state_nxt;
	logic [15:0] wake_cnt_r;
	logic [15:0] wake_cnt_nxt;
	// Doze is cleared by an interrupt when return-on-interrupt is set.
	logic doze_kill_r;
	// Bus answer is held one cycle so every access takes two edges.
	logic ack_r;

	// Register field views.
	wire ctl_wdt = ctrl_r[pmc_pkg::CTRL_WDT_POS];
	wire ctl_failsafe_clock_monitor = ctrl_r[pmc_pkg::CTRL_FAILSAFE_CLOCK_MONITOR_POS];
	wire ctl_regulator_standby_keep_bit = ctrl_r[pmc_pkg::CTRL_REGULATOR_STANDBY_KEEP_BIT_POS];
	wire ctl_lock = ctrl_r[pmc_pkg::CTRL_LOCK_POS];
	wire [2:0] ctl_new_oscillator_select = ctrl_r[pmc_pkg::CTRL_NEW_OSCILLATOR_SELECT_LSB +: 3];
	wire div_roi = clock_divider_register_r[pmc_pkg::CLOCK_DIVIDER_REGISTER_ROI_POS];
	wire div_core_slowdown_enable = clock_divider_register_r[pmc_pkg::CLOCK_DIVIDER_REGISTER_CORE_SLOWDOWN_ENABLE_POS];
	wire [2:0] div_ratio = clock_divider_register_r[pmc_pkg::CLOCK_DIVIDER_REGISTER_RATIO_LSB +: 3];

	// Bus decode; a request is taken on the edge where waitrequest is low.
	wire req = I_AVS_READ | I_AVS_WRITE;
	wire take = req & ack_r;
	wire wr_take = take & I_AVS_WRITE;
	wire sel_ctrl = (I_AVS_ADDRESS == pmc_pkg::ADDR_CTRL);
	wire sel_div = (I_AVS_ADDRESS == pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER);
	wire sel_mod = (I_AVS_ADDRESS == pmc_pkg::ADDR_MOD);
	wire sel_stat = (I_AVS_ADDRESS == pmc_pkg::ADDR_STATUS);
	wire [15:0] be_mask = {{8{I_AVS_BYTEENABLE[1]}},
		{8{I_AVS_BYTEENABLE[0]}}};
	wire [15:0] ctrl_wval = (ctrl_r & ~be_mask)
		| (I_AVS_WRITEDATA[15:0] & be_mask);
	wire [15:0] div_wval = (clock_divider_register_r & ~be_mask)
		| (I_AVS_WRITEDATA[15:0] & be_mask);

	// Wake events; reset is the asynchronous reset itself.
	wire wake_evt = I_IRQ_PEND | I_WDT_TIMEOUT;
	wire in_sleep = (state_r == pmc_pkg::ST_SLEEP);
	wire in_idle = (state_r == pmc_pkg::ST_IDLE);
	wire in_wake = (state_r == pmc_pkg::ST_WAKE);
	wire in_run = (state_r == pmc_pkg::ST_RUN);
	wire wake_done = (wake_cnt_r == 16'h0000);

	// Power state machine next-state logic.
	always_comb begin
		state_nxt = state_r;
		wake_cnt_nxt = wake_cnt_r;
		case (state_r)
			pmc_pkg::ST_RUN: begin
				// Entry completes before any pending interrupt is looked at.
				if (I_POWER_SAVE_INSTRUCTION) begin
					state_nxt = I_POWER_SAVE_INSTRUCTION_OPER ? pmc_pkg::ST_IDLE
						: pmc_pkg::ST_SLEEP;
				end
			end
			pmc_pkg::ST_SLEEP: begin
				// Oscillator must restart, plus regulator delay if in standby.
				if (wake_evt) begin
					state_nxt = pmc_pkg::ST_WAKE;
					wake_cnt_nxt = ctl_regulator_standby_keep_bit
						? 16'(pmc_pkg::OSC_START_CYC)
						: 16'(pmc_pkg::OSC_START_CYC + REG_WAKE_CYCLES);
				end
			end
			pmc_pkg::ST_IDLE: begin
				// The clock never stopped, so the core resumes next cycle.
				if (wake_evt) begin
					state_nxt = pmc_pkg::ST_RUN;
				end
			end
			pmc_pkg::ST_WAKE: begin
				if (wake_done) begin
					state_nxt = pmc_pkg::ST_RUN;
				end else begin
					wake_cnt_nxt = wake_cnt_r - 16'h0001;
				end
			end
			default: begin
				state_nxt = pmc_pkg::ST_RUN;
			end
		endcase
	end

	// State and counter registers; reset wakes from any mode.
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_r <= pmc_pkg::ST_RUN;
			wake_cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
		end
	end

	// Control and divider registers; the lock guards the oscillator field.
	wire [15:0] ctrl_keep = {ctl_lock ? ctl_new_oscillator_select : ctrl_wval[14:12],
		ctrl_wval[11:0]};
	wire [15:0] ctrl_fix = {ctrl_wval[15], ctrl_keep[14:0]};
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ctrl_r <= pmc_pkg::CTRL_RST;
			clock_divider_register_r <= pmc_pkg::CLOCK_DIVIDER_REGISTER_RST;
		end else begin
			if (wr_take && sel_ctrl) begin
				ctrl_r <= ctrl_fix;
			end
			if (wr_take && sel_div) begin
				clock_divider_register_r <= div_wval;
			end
		end
	end

	// Running oscillator follows the selection only while awake.
	// Sleep freezes it so wake resumes on the same source.
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			osc_run_r <= pmc_pkg::OSC_RST;
		end else if (in_run) begin
			osc_run_r <= ctl_new_oscillator_select;
		end
	end

	// Return-on-interrupt: an interrupt ends doze until doze is rewritten.
	// A write in the same cycle as an interrupt loses, so the event wins.
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			doze_kill_r <= 1'b0;
		end else if (div_roi && div_core_slowdown_enable && I_IRQ_PEND) begin
			doze_kill_r <= 1'b1;
		end else if (wr_take && sel_div) begin
			doze_kill_r <= 1'b0;
		end
	end

	// Module registers: disable in low byte group, enable, stop-in-idle.
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mod_dis_r <= '0;
			mod_en_r <= '0;
			mod_idl_r <= '0;
		end else if (wr_take && sel_mod) begin
			mod_dis_r <= I_AVS_WRITEDATA[NMOD-1:0];
			mod_en_r <= I_AVS_WRITEDATA[8 +: NMOD];
			mod_idl_r <= I_AVS_WRITEDATA[16 +: NMOD];
		end
	end

	// Doze drive into the divider.
	assign dz.enable = div_core_slowdown_enable & ~doze_kill_r;
	assign dz.ratio = div_ratio;
	pmc_doze_div u_div (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.dz(dz)
	);

	// Per-module clock and run decisions.
	logic [NMOD-1:0] mod_clk_nxt;
	logic [NMOD-1:0] mod_run_nxt;
	genvar g;
	generate
		for (g = 0; g < NMOD; g++) begin : g_mod
			// Sleep kills system-clocked modules; idle honours stop bit.
			// Next state is used so module clocks move with the core enable.
			assign mod_clk_nxt[g] = ~mod_dis_r[g]
				& ((state_nxt == pmc_pkg::ST_RUN)
				| ((state_nxt == pmc_pkg::ST_IDLE) & ~mod_idl_r[g]));
			assign mod_run_nxt[g] = mod_clk_nxt[g] & mod_en_r[g];
		end
	endgenerate

	// Status and read mux; unmapped offsets read zero.
	wire [31:0] stat_val = {16'h0000, 4'h0, 1'b0, osc_run_r,
		4'h0, state_r};
	wire [31:0] mod_val = {8'h00, 8'(mod_idl_r), 8'(mod_en_r),
		8'(mod_dis_r)};
	wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl_r}
		: sel_div ? {16'h0000, clock_divider_register_r}
		: sel_mod ? mod_val
		: sel_stat ? stat_val : 32'h0000_0000;

	// Registered outputs; state-based ones use the next state, except oscillator select and watchdog clear.
	wire core_on = (state_nxt == pmc_pkg::ST_RUN) & dz.core_tick;
	wire sleep_n = (state_nxt == pmc_pkg::ST_SLEEP);
	wire idle_n = (state_nxt == pmc_pkg::ST_IDLE);
	wire entering = in_run & I_POWER_SAVE_INSTRUCTION;
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_CORE_CLK_EN <= 1'b0;
			O_SYS_OSC_ON <= 1'b1;
			O_LOW_POWER_INTERNAL_OSCILLATOR_ON <= 1'b0;
			O_FAILSAFE_CLOCK_MONITOR_ACTIVE <= 1'b0;
			O_WDT_CLEAR <= 1'b0;
			O_REG_STANDBY <= 1'b0;
			O_OSC_SEL <= pmc_pkg::OSC_RST;
			O_MOD_CLK_EN <= '0;
			O_MOD_RUN <= '0;
			O_MOD_REG_ACCESS <= '0;
		end else begin
			O_CORE_CLK_EN <= core_on;
			O_SYS_OSC_ON <= ~sleep_n;
			O_LOW_POWER_INTERNAL_OSCILLATOR_ON <= ctl_wdt | (idle_n & ctl_failsafe_clock_monitor);
			O_FAILSAFE_CLOCK_MONITOR_ACTIVE <= ctl_failsafe_clock_monitor & ~sleep_n
				& (state_nxt != pmc_pkg::ST_WAKE);
			O_WDT_CLEAR <= entering & ctl_wdt;
			O_REG_STANDBY <= sleep_n & ~ctl_regulator_standby_keep_bit;
			O_OSC_SEL <= in_run ? ctl_new_oscillator_select : osc_run_r;
			O_MOD_CLK_EN <= mod_clk_nxt;
			O_MOD_RUN <= mod_run_nxt;
			O_MOD_REG_ACCESS <= ~mod_dis_r;
		end
	end

	// Bus handshake: waitrequest low one cycle after a request rises.
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ack_r <= 1'b0;
			O_AVS_WAITREQUEST <= 1'b1;
			O_AVS_READDATA <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			O_AVS_WAITREQUEST <= ~(req & ~ack_r);
			O_AVS_READDATA <= (I_AVS_READ & ~ack_r) ? rd_mux
				: 32'h0000_0000;
		end
	end

	// Sleep or idle is entered exactly one edge after the request.
	power_entry_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(in_run && I_POWER_SAVE_INSTRUCTION) |=> (I_POWER_SAVE_INSTRUCTION_OPER ? in_idle : in_sleep)
		== 1'b1)
		else $error("power save entry went to wrong state");
	// The oscillator is off throughout sleep.
	sleep_osc_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		in_sleep ##1 in_sleep |-> !O_SYS_OSC_ON)
		else $error("oscillator ran during sleep");
	// An idle wake gives the core back on the next edge.
	idle_wake_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(in_idle && wake_evt && !div_core_slowdown_enable) |-> ##1 in_run ##0 O_CORE_CLK_EN)
		else $error("idle wake did not restart core");
	// The watchdog is cleared on every entry with the watchdog on.
	wdt_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(in_run && I_POWER_SAVE_INSTRUCTION && ctl_wdt) |=> O_WDT_CLEAR)
		else $error("watchdog not cleared on entry");
	// The monitor is never active across a sleep.
	failsafe_clock_monitor_sleep_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		in_sleep |-> ##1 !O_FAILSAFE_CLOCK_MONITOR_ACTIVE)
		else $error("monitor active in sleep");
	// Low-power oscillator kept while sleeping with the watchdog on.
	low_power_internal_oscillator_keep_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(in_sleep && ctl_wdt) |=> O_LOW_POWER_INTERNAL_OSCILLATOR_ON)
		else $error("low-power oscillator stopped");
	// Oscillator selection cannot move while locked.
	lock_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		ctl_lock |=> $stable(ctl_new_oscillator_select))
		else $error("oscillator selection changed while locked");
	// A disabled module has no clock and no register access.
	mod_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(mod_dis_r[0] && $stable(mod_dis_r)) |=> (!O_MOD_CLK_EN[0]
		&& !O_MOD_REG_ACCESS[0]))
		else $error("disabled module still clocked");
endmodule : pmc_top

// File: testbench/pmc_core_model.sv
// Core model that executes power-save instructions and passes event lines through.
`timescale 1ns/1ps
module pmc_core_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_go,
	input wire logic i_oper,
	input wire logic i_irq,
	input wire logic i_wdt,
	input wire logic i_core_clk_en,
	output logic o_psv,
	output logic o_oper,
	output logic o_irq,
	output logic o_wdt
);
	// An instruction executes only while the core is clocked, so a request
	// waits for the enable; the self-clear keeps each request one pulse.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_psv <= 1'b0;
			o_oper <= 1'b0;
		end else begin
			o_psv <= i_go & i_core_clk_en & ~o_psv;
			o_oper <= i_oper;
		end
	end
	// Event lines are levels that the bench raises and drops itself.
	assign o_irq = i_irq;
	assign o_wdt = i_wdt;
endmodule : pmc_core_model

// File: testbench/tb.sv
// Self-checking bench for the power mode clock gating block.
`timescale 1ns/1ps
module tb;
	localparam int RW = 20; // Short regulator delay keeps the run brief.
	localparam int OS = pmc_pkg::OSC_START_CYC;
	logic clk = 1'b0;
	logic rst_b = 1'b0; // Active low reset.
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic go = 1'b0;
	logic oper = 1'b0;
	logic irq = 1'b0;
	logic wdt = 1'b0;
	logic psv, poper, irqp, wdto, wreq, core, sosc, lpo_on, mon_on, wclr;
	logic stby, ws;
	logic [2:0] osc;
	logic [7:0] mclk, mrun, macc;
	logic [31:0] rdata, rv;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	// Free-running system clock at 10 MHz.
	always #50 clk = ~clk;
	pmc_core_model i_pmc_core_model (.i_clk(clk), .i_rst_b(rst_b),
		.i_go(go), .i_oper(oper), .i_irq(irq), .i_wdt(wdt),
		.i_core_clk_en(core), .o_psv(psv), .o_oper(poper), .o_irq(irqp),
		.o_wdt(wdto));
	pmc_top #(.REG_WAKE_CYCLES(RW)) i_pmc_top (.I_CLK(clk),
		.I_RST_B(rst_b), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
		.I_AVS_BYTEENABLE(4'hf), .I_POWER_SAVE_INSTRUCTION(psv), .I_POWER_SAVE_INSTRUCTION_OPER(poper),
		.I_IRQ_PEND(irqp), .I_WDT_TIMEOUT(wdto), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(wreq), .O_CORE_CLK_EN(core), .O_SYS_OSC_ON(sosc),
		.O_LOW_POWER_INTERNAL_OSCILLATOR_ON(lpo_on), .O_FAILSAFE_CLOCK_MONITOR_ACTIVE(mon_on), .O_WDT_CLEAR(wclr),
		.O_REG_STANDBY(stby), .O_OSC_SEL(osc), .O_MOD_CLK_EN(mclk),
		.O_MOD_RUN(mrun), .O_MOD_REG_ACCESS(macc));
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// Compares with case equality so an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// Lets k edges pass and settles past the last one.
	task automatic tk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tk
	// Counts cycles until the core enable reaches v.
	task automatic wcore(input logic v, output int c);
		c = 0;
		while (core !== v && c < 2000) begin
			tk(1);
			c++;
		end
	endtask : wcore
	// Counts enabled core cycles over a window of k cycles.
	task automatic cnt(input int k, output int c);
		c = 0;
		repeat (k) begin
			if (core === 1'b1) c++;
			tk(1);
		end
	endtask : cnt
	// Issues one power-save instruction; ci raises an interrupt with it.
	task automatic psave(input logic o, input logic ci);
		@(posedge clk);
		go <= 1'b1;
		oper <= o;
		@(posedge clk);
		irq <= ci;
		do @(posedge clk); while (psv !== 1'b1);
		go <= 1'b0;
		#1;
		ws = wclr;
		wcore(1'b0, n);
	endtask : psave
	// Drops all event lines at the next edge.
	task automatic calm;
		@(posedge clk);
		irq <= 1'b0;
		wdt <= 1'b0;
	endtask : calm
	// Watchdog sized well above the under two thousand cycles the tests need.
	initial begin
		#(20000 * 100);
		num_errors++;
		report_and_stop;
	end
	// Main sequence of scenarios.
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		tk(2);
		bus(0, pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 0); chk(rv, 32'h0);
		bus(0, pmc_pkg::ADDR_STATUS, 0); chk(rv, 32'h1);
		bus(0, 4'h2, 0); chk(rv, 32'h0);
		// Sleep with watchdog and monitor on, regulator kept.
		bus(1, pmc_pkg::ADDR_CTRL, 32'h310c);
		tk(3); chk(osc, 3'h3);
		chk(mon_on, 1'b1);
		psave(1'b0, 1'b0); chk(sosc, 1'b0);
		chk(ws, 1'b1);
		chk(lpo_on, 1'b1);
		chk(mon_on, 1'b0);
		chk(mclk, 8'h00);
		chk(stby, 1'b0);
		tk(4); chk(core, 1'b0);
		@(posedge clk); irq <= 1'b1;
		wcore(1'b1, n); chk(32'(n >= OS && n <= OS + 4), 32'h1);
		chk(osc, 3'h3);
		calm;
		// Sleep with regulator standby, woken by a time-out.
		bus(1, pmc_pkg::ADDR_CTRL, 32'h3008);
		psave(1'b0, 1'b0); chk(stby, 1'b1);
		@(posedge clk); wdt <= 1'b1;
		wcore(1'b1, n); chk(32'(n >= RW + OS), 32'h1);
		calm;
		// Idle with monitor only and module 0 stopping in idle.
		bus(1, pmc_pkg::ADDR_MOD, 32'h01ff00);
		psave(1'b1, 1'b0); chk(sosc, 1'b1);
		chk(lpo_on, 1'b1);
		tk(1); chk(mrun, 8'hfe);
		bus(0, pmc_pkg::ADDR_STATUS, 0); chk(rv, 32'h304);
		@(posedge clk); irq <= 1'b1;
		wcore(1'b1, n); chk(32'(n <= 3), 32'h1);
		calm;
		tk(2); chk(mrun, 8'hff);
		// Interrupt coincident with idle entry, watchdog on.
		bus(1, pmc_pkg::ADDR_CTRL, 32'h3004);
		psave(1'b1, 1'b1); chk(ws, 1'b1);
		wcore(1'b1, n); chk(32'(n <= 4), 32'h1);
		calm;
		// A reset wakes from sleep.
		psave(1'b0, 1'b0);
		@(posedge clk); rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		tk(2); chk(core, 1'b1);
		chk(sosc, 1'b1);
		// Clock disable against function enable.
		bus(1, pmc_pkg::ADDR_MOD, 32'h00f005);
		tk(2); chk(mclk, 8'hfa);
		chk(macc, 8'hfa);
		chk(mrun, 8'hf0);
		// Oscillator selection freezes once locked.
		bus(1, pmc_pkg::ADDR_CTRL, 32'h3200);
		bus(1, pmc_pkg::ADDR_CTRL, 32'h5200);
		bus(0, pmc_pkg::ADDR_CTRL, 0); chk(rv, 32'h3200);
		// Every doze ratio thins the core enable by two to the power n.
		for (int r = 0; r < 8; r++) begin
			bus(1, pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h800 | (r << 12));
			tk(4);
			cnt(128, n); chk(32'(n), 32'(128 >> r));
			chk(mclk, 8'hfa);
		end
		// Interrupts leave doze alone unless return is armed.
		bus(1, pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h1800);
		@(posedge clk); irq <= 1'b1;
		tk(3); cnt(16, n); chk(32'(n), 32'h8);
		calm;
		bus(1, pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h9800);
		@(posedge clk); irq <= 1'b1;
		tk(3); cnt(16, n); chk(32'(n), 32'h10);
		calm;
		bus(1, pmc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h1000);
		tk(4); cnt(16, n); chk(32'(n), 32'h10);
		report_and_stop;
	end
endmodule : tb
